/* hdl/ict_pkg.sv */
// Constants shared by the interval countdown timer design
package ict_pkg;

	localparam int          ICT_DATA_W         = 16;
	localparam int          ICT_ADDR_W         = 4;

	// Register word indices; period words start at ICT_OFS_PERIOD, snapshot words follow them
	localparam logic [3:0]  ICT_OFS_STATUS     = 4'h0;
	localparam logic [3:0]  ICT_OFS_CONTROL    = 4'h1;
	localparam logic [3:0]  ICT_OFS_PERIOD     = 4'h2;

	// Status bit positions
	localparam int          ICT_ST_TO          = 0;
	localparam int          ICT_ST_RUN         = 1;

	// Control bit positions
	localparam int          ICT_CT_ITO         = 0;
	localparam int          ICT_CT_CONT        = 1;
	localparam int          ICT_CT_START       = 2;
	localparam int          ICT_CT_STOP        = 3;

	localparam int          ICT_COUNT_W_DEF    = 32;
	localparam longint      ICT_CLK_PERIOD_NS  = 64'd100;
	localparam longint      ICT_TIMEOUT_NS_DEF = 64'd1000000;

	typedef enum logic {
		ICT_IDLE = 1'b0,
		ICT_RUN  = 1'b1
	} ict_run_type;

endpackage : ict_pkg

/* hdl/ict_timer.sv */
// Interval countdown timer with 16-bit register port, pulse and watchdog outputs
`timescale 1ns/1ps
module ict_timer
	import ict_pkg::*;
#(
	parameter int     COUNT_W          = ICT_COUNT_W_DEF,
	parameter longint TIMEOUT_NS       = ICT_TIMEOUT_NS_DEF,
	parameter bit     WRITEABLE_PERIOD = 1'b1,
	parameter bit     READABLE_SNAP    = 1'b1,
	parameter bit     START_STOP       = 1'b1,
	parameter bit     PULSE_EN         = 1'b1,
	parameter bit     WATCHDOG         = 1'b0
) (
	input  wire logic                  core_clk_i,
	input  wire logic                  arst_n_i,
	input  wire logic                  reg_wr_i,
	input  wire logic [ICT_ADDR_W-1:0] reg_addr_i,
	input  wire logic [ICT_DATA_W-1:0] reg_wdata_i,
	output logic      [ICT_DATA_W-1:0] reg_rdata_o,
	output logic                       irq_o,
	output logic                       timeout_pulse_o,
	output logic                       reset_req_o
);

	localparam int              NW        = COUNT_W / ICT_DATA_W;
	localparam logic [3:0]      OFS_SNAP  = ICT_OFS_PERIOD + 4'(NW);
	localparam longint          CYC_RAW   = (TIMEOUT_NS + ICT_CLK_PERIOD_NS - 64'd1) / ICT_CLK_PERIOD_NS;
	localparam longint          CYC       = (CYC_RAW < 64'd1) ? 64'd1 : CYC_RAW;
	localparam logic [COUNT_W-1:0] PERIOD_RST = COUNT_W'(CYC - 64'd1);
	localparam bit              START_OK  = START_STOP || WATCHDOG;
	localparam bit              STOP_OK   = START_STOP && !WATCHDOG;
	// Without start control the timer must run from reset on
	localparam ict_run_type     RUN_RST   = START_OK ? ICT_IDLE : ICT_RUN;

	// Only 32 and 64 bits, two or four of the 16-bit words that the snapshot and period words cover, are served
	if (COUNT_W != 32 && COUNT_W != 64) begin : g_bad_width
		$error("COUNT_W must be 32 or 64");
	end

	ict_run_type        run;
	ict_run_type        next_run;
	logic [COUNT_W-1:0] cnt;
	logic [COUNT_W-1:0] next_cnt;
	logic [COUNT_W-1:0] snap;
	logic [COUNT_W-1:0] next_snap;
	logic [COUNT_W-1:0] period;
	logic               to_flag;
	logic               next_to;
	logic               ito;
	logic               next_ito;
	logic               cont;
	logic               next_cont;
	logic               reload_pend;
	logic               next_reload;
	logic               next_irq;
	logic               next_pulse;
	logic               next_rst_req;
	logic [ICT_DATA_W-1:0] next_rdata;
	logic               ctrl_wr;
	logic               stat_wr;
	logic               period_wr;
	logic               snap_wr;
	logic               zero_hit;

	assign ctrl_wr   = reg_wr_i && (reg_addr_i == ICT_OFS_CONTROL);
	assign stat_wr   = reg_wr_i && (reg_addr_i == ICT_OFS_STATUS);
	assign period_wr = reg_wr_i && (reg_addr_i >= ICT_OFS_PERIOD) && (reg_addr_i < OFS_SNAP);
	assign snap_wr   = READABLE_SNAP && reg_wr_i && (reg_addr_i >= OFS_SNAP)
	                   && (reg_addr_i < OFS_SNAP + 4'(NW));
	// A zero count only counts as an arrival while running, so a stopped timer raises nothing
	assign zero_hit  = (run == ICT_RUN) && (cnt == '0);

	// Period words exist only when software may change them
	if (WRITEABLE_PERIOD) begin : g_period_regs
		for (genvar g = 0; g < NW; g++) begin : g_word
			ict_word_reg #(
				.RST_VAL (PERIOD_RST[g*ICT_DATA_W +: ICT_DATA_W])
			) u_word (
				.core_clk_i (core_clk_i),
				.arst_n_i   (arst_n_i),
				.wr_en_i    (reg_wr_i && (reg_addr_i == ICT_OFS_PERIOD + 4'(g))),
				.d_i        (reg_wdata_i),
				.q_o        (period[g*ICT_DATA_W +: ICT_DATA_W])
			);
		end
	end else begin : g_period_fixed
		assign period = PERIOD_RST;
	end

	always_comb begin
		next_run     = run;
		next_cnt     = cnt;
		next_cont    = cont;
		next_ito     = ito;
		next_to      = to_flag;
		next_snap    = snap;
		// Reload one cycle after a period write so the new word is already in place
		next_reload  = period_wr;
		if (run == ICT_RUN) begin
			if (cnt == '0) begin
				next_cnt = period;
				if (STOP_OK && !cont) begin
					next_run = ICT_IDLE;
				end
			end else begin
				next_cnt = cnt - 1'b1;
			end
		end
		if (reload_pend) begin
			next_cnt = period;
		end
		if (ctrl_wr) begin
			next_ito  = reg_wdata_i[ICT_CT_ITO];
			next_cont = reg_wdata_i[ICT_CT_CONT];
			if (START_OK && reg_wdata_i[ICT_CT_START]) begin
				next_run = ICT_RUN;
			end
			// Stop wins when both bits are written together
			if (STOP_OK && reg_wdata_i[ICT_CT_STOP]) begin
				next_run = ICT_IDLE;
			end
		end
		if (stat_wr) begin
			next_to = 1'b0;
		end
		// A zero arrival in the clearing cycle is kept
		if (zero_hit) begin
			next_to = 1'b1;
		end
		// Whole counter is copied at once so the words read later always belong together
		if (snap_wr) begin
			next_snap = cnt;
		end
		next_irq     = next_to && next_ito;
		next_pulse   = PULSE_EN && zero_hit;
		next_rst_req = WATCHDOG && zero_hit;
	end

	// Read data is registered: it answers the address of the previous cycle
	always_comb begin
		next_rdata = '0;
		unique case (1'b1)
			(reg_addr_i == ICT_OFS_STATUS): begin
				next_rdata[ICT_ST_TO]  = to_flag;
				next_rdata[ICT_ST_RUN] = (run == ICT_RUN);
			end
			(reg_addr_i == ICT_OFS_CONTROL): begin
				next_rdata[ICT_CT_ITO]  = ito;
				next_rdata[ICT_CT_CONT] = cont;
			end
			default: begin
				for (int i = 0; i < NW; i++) begin
					if (WRITEABLE_PERIOD && reg_addr_i == ICT_OFS_PERIOD + 4'(i)) begin
						next_rdata = period[i*ICT_DATA_W +: ICT_DATA_W];
					end
					// Absent snapshot words read as zero
					if (READABLE_SNAP && reg_addr_i == OFS_SNAP + 4'(i)) begin
						next_rdata = snap[i*ICT_DATA_W +: ICT_DATA_W];
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			run             <= RUN_RST;
			cnt             <= PERIOD_RST;
			cont            <= 1'b0;
			ito             <= 1'b0;
			to_flag         <= 1'b0;
			snap            <= '0;
			reload_pend     <= 1'b0;
			irq_o           <= 1'b0;
			timeout_pulse_o <= 1'b0;
			reset_req_o     <= 1'b0;
			reg_rdata_o     <= '0;
		end else begin
			run             <= next_run;
			cnt             <= next_cnt;
			cont            <= next_cont;
			ito             <= next_ito;
			to_flag         <= next_to;
			snap            <= next_snap;
			reload_pend     <= next_reload;
			irq_o           <= next_irq;
			timeout_pulse_o <= next_pulse;
			reset_req_o     <= next_rst_req;
			reg_rdata_o     <= next_rdata;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	zero_reload_a: assert property (zero_hit && !reload_pend |=> cnt == $past(period))
		else $error("counter did not reload at zero");
	count_down_a: assert property ((run == ICT_RUN) && cnt != '0 && !reload_pend
		|=> cnt == $past(cnt) - COUNT_W'(1))
		else $error("counter did not decrement");
	irq_raise_a: assert property (zero_hit && ito && !ctrl_wr |=> irq_o)
		else $error("interrupt missing after zero");
	irq_mask_a: assert property (!ito && !ctrl_wr |=> !irq_o)
		else $error("interrupt raised while disabled");
	pulse_width_a: assert property (timeout_pulse_o |=> !timeout_pulse_o)
		else $error("pulse wider than one cycle");
	pulse_cause_a: assert property (PULSE_EN && zero_hit |=> timeout_pulse_o)
		else $error("pulse missing after zero");
	wdog_req_a: assert property (WATCHDOG && zero_hit |=> reset_req_o)
		else $error("reset request missing after zero");
	wdog_stay_a: assert property (WATCHDOG && run == ICT_RUN |=> run == ICT_RUN)
		else $error("watchdog stopped after start");
	snap_take_a: assert property (snap_wr |=> snap == $past(cnt))
		else $error("snapshot not coherent");
	one_shot_a: assert property (STOP_OK && zero_hit && !cont && !ctrl_wr
		|=> run == ICT_IDLE ##1 (run == ICT_IDLE || $past(ctrl_wr)))
		else $error("one-shot did not stop");
	status_to_a: assert property (zero_hit |=> to_flag)
		else $error("timeout flag not set");
	fixed_period_a: assert property (!WRITEABLE_PERIOD |-> period == PERIOD_RST)
		else $error("fixed period changed");

	// Start, stop and free-running behaviour
	run_free_a: assert property (!START_OK |-> run == ICT_RUN)
		else $error("free-running timer halted");
	stop_wins_a: assert property (STOP_OK && ctrl_wr && reg_wdata_i[ICT_CT_STOP]
		|=> run == ICT_IDLE)
		else $error("stop bit ignored");
	start_take_a: assert property (START_OK && ctrl_wr && reg_wdata_i[ICT_CT_START]
		&& !(STOP_OK && reg_wdata_i[ICT_CT_STOP]) |=> run == ICT_RUN)
		else $error("start bit ignored");
	count_hold_a: assert property (run == ICT_IDLE && !reload_pend
		|=> cnt == $past(cnt))
		else $error("stopped counter moved");

	// Register writes and reads
	ito_write_a: assert property (ctrl_wr
		|=> ito == $past(reg_wdata_i[ICT_CT_ITO]))
		else $error("interrupt enable not taken");
	cont_write_a: assert property (ctrl_wr
		|=> cont == $past(reg_wdata_i[ICT_CT_CONT]))
		else $error("mode bit not taken");
	to_clear_a: assert property (stat_wr && !zero_hit
		|=> !to_flag)
		else $error("timeout flag not cleared");
	rdata_stat_a: assert property (reg_addr_i == ICT_OFS_STATUS
		|=> reg_rdata_o[ICT_ST_TO] == $past(to_flag)
		&& reg_rdata_o[ICT_ST_RUN] == $past(run == ICT_RUN))
		else $error("status read wrong");
	period_write_a: assert property (WRITEABLE_PERIOD && reg_wr_i && reg_addr_i == ICT_OFS_PERIOD
		|=> period[ICT_DATA_W-1:0] == $past(reg_wdata_i))
		else $error("period word not written");
	rdata_period_a: assert property (WRITEABLE_PERIOD && reg_addr_i == ICT_OFS_PERIOD
		|=> reg_rdata_o == $past(period[ICT_DATA_W-1:0]))
		else $error("period read wrong");
	rdata_snap_a: assert property (READABLE_SNAP && reg_addr_i == OFS_SNAP
		|=> reg_rdata_o == $past(snap[ICT_DATA_W-1:0]))
		else $error("snapshot read wrong");
	snap_hold_a: assert property (!snap_wr
		|=> snap == $past(snap))
		else $error("snapshot changed without request");
	no_snap_a: assert property (!READABLE_SNAP |-> snap == '0)
		else $error("absent snapshot holds data");

	// Reload after a period write and the option outputs
	reload_pend_a: assert property (period_wr
		|=> reload_pend)
		else $error("period write did not arm reload");
	wdog_reload_a: assert property (reload_pend
		|=> cnt == $past(period))
		else $error("count not reloaded after period write");
	pulse_off_a: assert property (!PULSE_EN |-> !timeout_pulse_o)
		else $error("pulse from an absent output");
	wdog_off_a: assert property (!WATCHDOG |-> !reset_req_o)
		else $error("reset request without watchdog");

	zero_seen_c: cover property (zero_hit);
	snap_read_c: cover property (snap_wr ##1 reg_addr_i == OFS_SNAP);
	stop_c: cover property (ctrl_wr && reg_wdata_i[ICT_CT_STOP] ##1 run == ICT_IDLE);
	reload_c: cover property (period_wr ##2 cnt == period);
	wdog_req_c: cover property (reset_req_o);

endmodule : ict_timer

/* hdl/ict_word_reg.sv */
// One 16-bit period word with its own reset value and write enable
`timescale 1ns/1ps
module ict_word_reg
	import ict_pkg::*;
#(
	parameter logic [ICT_DATA_W-1:0] RST_VAL = 16'h0000
) (
	input  wire logic                  core_clk_i,
	input  wire logic                  arst_n_i,
	input  wire logic                  wr_en_i,
	input  wire logic [ICT_DATA_W-1:0] d_i,
	output logic      [ICT_DATA_W-1:0] q_o
);

	logic [ICT_DATA_W-1:0] next_q;

	always_comb begin
		next_q = q_o;
		if (wr_en_i) begin
			next_q = d_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q_o <= RST_VAL;
		end else begin
			q_o <= next_q;
		end
	end

endmodule : ict_word_reg

/* tb/ict_bus_master.sv */
// Processor-side register master model that drives the timer's write strobe and reads its registers
`timescale 1ns/1ps
module ict_bus_master
	import ict_pkg::*;
(
	input  wire logic                  core_clk_i,
	input  wire logic [ICT_DATA_W-1:0] rdata_i,
	output logic                       wr_o,
	output logic      [ICT_ADDR_W-1:0] addr_o,
	output logic      [ICT_DATA_W-1:0] wdata_o
);
	initial begin
		wr_o = 1'b0;
		addr_o = ICT_OFS_STATUS;
		wdata_o = 16'h0000;
	end
	// One-cycle strobe; data is inverted after the write so a stale value can never pass
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge core_clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask : wr
	// Read data is registered, so it lands one edge after the address
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge core_clk_i);
		addr_o <= a;
		@(posedge core_clk_i);
		#1;
		d = rdata_i;
	endtask : rd
endmodule : ict_bus_master

/* tb/ict_timer_bench.sv */
// Self-checking bench for the interval countdown timer
`timescale 1ns/1ps
module ict_timer_bench;
	import ict_pkg::*;
	// Short timeout keeps the run brief: 1000 ns gives a 10-cycle period
	localparam int PER = 10;
	logic        core_clk_i, arst_n_i, reg_wr, pulse, irq, rst_req;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, v;
	logic        rst_req_wd;
	logic [15:0] rdata_wd;
	int          fails, n_checks, n;

	ict_timer #(.TIMEOUT_NS(64'd1000)) u_ict_timer (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
		.reg_wr_i(reg_wr), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.irq_o(irq), .timeout_pulse_o(pulse), .reset_req_o(rst_req));
	// Watchdog build on the same bus: it sees every write of the scenarios
	ict_timer #(.TIMEOUT_NS(64'd1000), .WRITEABLE_PERIOD(1'b0), .READABLE_SNAP(1'b0), .START_STOP(1'b0),
		.PULSE_EN(1'b0), .WATCHDOG(1'b1)) u_ict_timer_wd (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
		.reg_wr_i(reg_wr), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata_wd),
		.irq_o(), .timeout_pulse_o(), .reset_req_o(rst_req_wd));
	ict_bus_master u_ict_bus_master (.core_clk_i(core_clk_i), .rdata_i(rdata), .wr_o(reg_wr),
		.addr_o(addr), .wdata_o(wdata));

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic chk_bit(input logic g, input logic e);
		chk({15'h0000, g}, {15'h0000, e});
	endtask : chk_bit
	// Counts edges up to the next pulse; 200 means none came
	task automatic wait_pulse(output int c);
		c = 0;
		do begin
			@(posedge core_clk_i);
			#1;
			c++;
		end while (pulse !== 1'b1 && c < 200);
	endtask : wait_pulse
	task automatic end_sim();
		if (fails == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim

	task automatic t_reset();
		u_ict_bus_master.rd(ICT_OFS_STATUS, v);
		chk(v, 16'h0000);
		chk(rdata_wd, 16'h0000);
		u_ict_bus_master.rd(ICT_OFS_PERIOD, v);
		chk(v, 16'(PER - 1));
		u_ict_bus_master.rd(ICT_OFS_PERIOD + 4'h1, v);
		chk(v, 16'h0000);
	endtask : t_reset
	task automatic t_cont();
		u_ict_bus_master.wr(ICT_OFS_CONTROL, 16'h0007);
		wait_pulse(n);
		chk_bit(rst_req_wd, 1'b1);
		chk_bit(rst_req, 1'b0);
		wait_pulse(n);
		chk(n[15:0], 16'(PER));
		@(posedge core_clk_i);
		#1;
		chk_bit(pulse, 1'b0);
		u_ict_bus_master.rd(ICT_OFS_STATUS, v);
		chk(v, 16'h0003);
		chk(rdata_wd, 16'h0003);
		chk_bit(irq, 1'b1);
		u_ict_bus_master.wr(ICT_OFS_STATUS, 16'h0000);
		u_ict_bus_master.rd(ICT_OFS_STATUS, v);
		chk(v, 16'h0002);
		chk_bit(irq, 1'b0);
	endtask : t_cont
	task automatic t_mask();
		u_ict_bus_master.wr(ICT_OFS_CONTROL, 16'h0006);
		wait_pulse(n);
		u_ict_bus_master.rd(ICT_OFS_STATUS, v);
		chk(v, 16'h0003);
		chk_bit(irq, 1'b0);
		u_ict_bus_master.wr(ICT_OFS_STATUS, 16'h0000);
	endtask : t_mask
	task automatic t_period();
		u_ict_bus_master.wr(ICT_OFS_PERIOD, 16'h0004);
		u_ict_bus_master.wr(ICT_OFS_PERIOD + 4'h1, 16'h0000);
		wait_pulse(n);
		wait_pulse(n);
		chk(n[15:0], 16'h0005);
		u_ict_bus_master.rd(ICT_OFS_PERIOD, v);
		chk(v, 16'h0004);
	endtask : t_period
	// Snapshot taken two edges after the pulse: the count standing at that edge is 3
	task automatic t_snap();
		wait_pulse(n);
		u_ict_bus_master.wr(ICT_OFS_PERIOD + 4'h2, 16'h0000);
		u_ict_bus_master.rd(ICT_OFS_PERIOD + 4'h2, v);
		chk(v, 16'h0003);
		u_ict_bus_master.rd(ICT_OFS_PERIOD + 4'h3, v);
		chk(v, 16'h0000);
	endtask : t_snap
	task automatic t_oneshot();
		u_ict_bus_master.wr(ICT_OFS_STATUS, 16'h0000);
		u_ict_bus_master.wr(ICT_OFS_CONTROL, 16'h0005);
		wait_pulse(n);
		u_ict_bus_master.rd(ICT_OFS_STATUS, v);
		chk(v, 16'h0001);
		wait_pulse(n);
		chk(n[15:0], 16'h00c8);
	endtask : t_oneshot
	// Stop and start in one write: stop must win
	task automatic t_stop();
		u_ict_bus_master.wr(ICT_OFS_CONTROL, 16'h0006);
		u_ict_bus_master.wr(ICT_OFS_CONTROL, 16'h000e);
		u_ict_bus_master.rd(ICT_OFS_STATUS, v);
		chk(v & 16'h0002, 16'h0000);
		wait_pulse(n);
		chk(n[15:0], 16'h00c8);
	endtask : t_stop
	// Watchdog ignores stop; two period writes fix the phase, then one reload edge plus PER edges to the reset request
	task automatic t_wdog();
		u_ict_bus_master.wr(ICT_OFS_CONTROL, 16'h0008);
		u_ict_bus_master.rd(ICT_OFS_STATUS, v);
		chk(rdata_wd & 16'h0002, 16'h0002);
		u_ict_bus_master.wr(ICT_OFS_PERIOD, 16'h1234);
		u_ict_bus_master.wr(ICT_OFS_PERIOD + 4'h1, 16'h5678);
		n = 0;
		do begin
			@(posedge core_clk_i);
			#1;
			n++;
		end while (rst_req_wd !== 1'b1 && n < 200);
		chk(n[15:0], 16'(PER + 1));
		@(posedge core_clk_i);
		#1;
		chk_bit(rst_req_wd, 1'b0);
	endtask : t_wdog

	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end
	initial begin
		#300000;
		fails++;
		end_sim();
	end
	initial begin
		fails = 0;
		n_checks = 0;
		arst_n_i = 1'b0;
		repeat (3) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		t_reset();
		t_cont();
		t_mask();
		t_period();
		t_snap();
		t_oneshot();
		t_stop();
		t_wdog();
		end_sim();
	end
endmodule : ict_timer_bench
